/* rtl/rms_pkg.sv */
/*
 * Constants, register map, state encodings and the state record for the
 * reset sequencer, mode latch and clock distribution block.
 * Assumes a single 100 MHz bus clock and a 32-bit classic Wishbone slave.
 */
package rms_pkg;

    // ************************************************************
    // Clock and timing
    // ************************************************************
    localparam int unsigned CLK_HZ          = 100_000_000;
    localparam logic [5:0]  RST_DRIVE_CYC   = 6'd34;
    localparam logic [5:0]  RST_SAMPLE_CYC  = 6'd38;
    localparam logic [3:0]  BDC_BIT_LAST    = 4'd15;
    localparam logic [3:0]  BDC_SAMPLE_AT   = 4'd10;
    localparam logic [3:0]  BDC_ONE_LOW_END = 4'd4;
    localparam logic [3:0]  BDC_ZERO_LOW_END = 4'd13;
    localparam logic [2:0]  BDC_LAST_BIT    = 3'd7;
    localparam logic [3:0]  FF_WIN_LAST     = 4'd15;
    localparam logic [7:0]  FF_RATIO        = 8'd4;
    localparam logic [7:0]  FF_WIN_TICKS    = 8'd16;
    localparam logic [7:0]  FF_THRESH       = 8'(FF_RATIO * FF_WIN_TICKS);

    // ************************************************************
    // Register offsets (byte addresses)
    // ************************************************************
    localparam logic [7:0] OFS_CTRL     = 8'h00;
    localparam logic [7:0] OFS_CAUSE    = 8'h04;
    localparam logic [7:0] OFS_STATUS   = 8'h08;
    localparam logic [7:0] OFS_INT_STAT = 8'h0C;
    localparam logic [7:0] OFS_INT_MASK = 8'h10;
    localparam logic [7:0] OFS_BDC_TX   = 8'h14;
    localparam logic [7:0] OFS_BDC_RX   = 8'h18;

    // ************************************************************
    // Field positions
    // ************************************************************
    localparam int CTRL_CGO_SEL = 0;
    localparam int CTRL_BDC_CLK = 2;
    localparam int CTRL_RTI_SEL = 3;
    localparam int CTRL_ADC_SEL = 4;
    localparam int CTRL_STOP_RC = 5;
    localparam int CTRL_SW_RST  = 7;

    localparam int CAUSE_POR  = 0;
    localparam int CAUSE_PIN  = 1;
    localparam int CAUSE_COP  = 2;
    localparam int CAUSE_ILOP = 3;
    localparam int CAUSE_ILAD = 4;
    localparam int CAUSE_LVD  = 5;
    localparam int CAUSE_SW   = 6;

    localparam int EV_DONE   = 0;
    localparam int EV_BGMODE = 1;
    localparam int EV_PINLOW = 2;
    localparam int EV_RX     = 3;
    localparam int EV_TX     = 4;
    localparam int EV_FFS    = 5;

    localparam logic [1:0] CGO_XTAL = 2'b00;
    localparam logic [1:0] CGO_EXT  = 2'b01;
    localparam logic [1:0] CGO_DCO  = 2'b10;

    // ************************************************************
    // States and state record
    // ************************************************************
    typedef enum logic [3:0] {
        RS_RUN   = 4'b0001,
        RS_DRIVE = 4'b0010,
        RS_WAIT  = 4'b0100,
        RS_HOLD  = 4'b1000
    } rms_rst_state_t;

    typedef enum logic [1:0] {
        BD_IDLE = 2'b01,
        BD_BIT  = 2'b10
    } rms_bdc_state_t;

    typedef struct packed {
        rms_rst_state_t rs;
        logic [5:0]     rcnt;
        logic [7:0]     cause;
        logic           internal_src;
        logic           sys_reset;
        logic           bg_mode;
        logic           dbg_func;
        logic           selfclk;
        logic [1:0]     rpin_s;
        logic [1:0]     dpin_s;
        logic           dpin_prev;
        logic           rpin_o;
        logic           rpin_oe;
        logic [1:0]     cgo_sel;
        logic           bdc_clk_sel;
        logic           rti_sel;
        logic           adc_sel;
        logic           stop_rec;
        logic [7:0]     int_stat;
        logic [7:0]     int_mask;
        logic           irq;
        logic           ack;
        logic [31:0]    rdata;
        logic [7:0]     cgo_cnt;
        logic [3:0]     win_cnt;
        logic           ffs;
        logic           ff_phase;
        logic           ff_tick;
        rms_bdc_state_t bs;
        logic [3:0]     bcnt;
        logic [2:0]     bitn;
        logic [7:0]     tx;
        logic           tx_busy;
        logic [7:0]     rx;
        logic           dbg_o;
        logic           dbg_oe;
    } rms_state_t;

    localparam rms_state_t RMS_STATE_RST = '{
        rs:           RS_DRIVE,
        cause:        8'h01,
        internal_src: 1'b1,
        sys_reset:    1'b1,
        selfclk:      1'b1,
        rpin_s:       2'b11,
        dpin_s:       2'b11,
        dpin_prev:    1'b1,
        rpin_oe:      1'b1,
        cgo_sel:      CGO_DCO,
        bs:           BD_IDLE,
        default:      '0
    };

endpackage

/* rtl/rms_reset_seq.sv */
/*
 * Reset pin sequencer, reset cause record, mode-select latch, minimal
 * single-wire debug bit engine and clock distribution selects.
 * Assumes internal reset sources and clock ticks are bus-clock pulses;
 * both pins are open drain with external pullups, resolved by the bench.
 */
// Design decisions made here: the Wishbone slave port and the register addresses.
// Behaviour
// [RQ1] Fixed-frequency select high when clock output exceeds four times reference.
// [RQ2] Clock output source is crystal, external clock or controlled oscillator.
// [RQ3] Any reset drives pin low 34 cycles, releases, samples 38 later.
// [RQ4] Internal reset expects pin sample high; low means external hold.
// [RQ5] Each reset cause sets its matching bit in cause register; code leaves pin bit clear when an internal source fires in the same cycle.
// [RQ6] Debug pin is mode input in reset; high gives normal mode.
// [RQ7] Debug pin low at reset release gives active background mode.
// [RQ8] After release the debug pin switches to debug communication.
// [RQ9] Debug link bit time is sixteen debug clock cycles; code counts sixteen bus clock cycles whatever the debug clock select.
// [RQ10] Device releasing the debug pin drives a short high speedup pulse.
// [RQ11] Self-clocked source runs during reset, optionally for stop recovery.
// [RQ12] Tools may select the local self clock as debug clock.
// [RQ13] Reference clock selectable for real-time interrupt and converter clock.
// [RQ14] Internal logic held in reset until sample taken and mode latched.
`timescale 1ns/1ps
`default_nettype none

module rms_reset_seq
(
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [7:0]  wb_adr_i,
    input  wire logic [31:0] wb_dat_i,
    input  wire logic [3:0]  wb_sel_i,
    output logic      [31:0] wb_dat_o,
    output logic             wb_ack_o,
    input  wire logic        lvd_i,
    input  wire logic        cop_i,
    input  wire logic        ilop_i,
    input  wire logic        ilad_i,
    input  wire logic        cgo_tick_i,
    input  wire logic        erc_tick_i,
    input  wire logic        rst_pin_i,
    output logic             rst_pin_o,
    output logic             rst_pin_oe_o,
    input  wire logic        dbg_pin_i,
    output logic             dbg_pin_o,
    output logic             dbg_pin_oe_o,
    output logic             sys_reset_o,
    output logic             bg_mode_o,
    output logic             dbg_func_o,
    output logic             fixed_freq_select_o,
    output logic             ff_tick_o,
    output logic      [1:0]  cgo_sel_o,
    output logic             bdc_clk_sel_o,
    output logic             rti_clk_sel_o,
    output logic             adc_alt_clk_sel_o,
    output logic             selfclk_run_o,
    output logic             irq_o
);
    import rms_pkg::*;

    // ************************************************************
    // Address decode
    // ************************************************************
    function automatic logic rms_hit(input logic [7:0] a, input logic [7:0] ofs);
        rms_hit = (a[7:2] == ofs[7:2]);
    endfunction

    rms_state_t s_r;
    rms_state_t s_nxt;

    // ************************************************************
    // Next state
    // ************************************************************
    always_comb begin
        logic       req;
        logic       wr;
        logic [7:0] ev;
        logic [7:0] clr;
        logic       sw_rst;
        logic       int_trig;
        logic       ext_trig;
        logic       release_now;
        logic [3:0] low_end;
        req         = 1'b0;
        wr          = 1'b0;
        ev          = 8'h00;
        clr         = 8'h00;
        sw_rst      = 1'b0;
        int_trig    = 1'b0;
        ext_trig    = 1'b0;
        release_now = 1'b0;
        low_end     = 4'h0;
        s_nxt       = s_r;

        // Pin synchronisers
        s_nxt.rpin_s    = {s_r.rpin_s[0], rst_pin_i};
        s_nxt.dpin_s    = {s_r.dpin_s[0], dbg_pin_i};
        s_nxt.dpin_prev = s_r.dpin_s[1];

        // Bus slave, one wait state
        req       = wb_cyc_i & wb_stb_i & ~s_r.ack;
        wr        = req & wb_we_i & wb_sel_i[0];
        s_nxt.ack = req;
        if (req) begin
            s_nxt.rdata = 32'h0000_0000;
            if (rms_hit(wb_adr_i, OFS_CTRL)) begin
                s_nxt.rdata[5:0] = {s_r.stop_rec, s_r.adc_sel, s_r.rti_sel,
                                    s_r.bdc_clk_sel, s_r.cgo_sel};
            end else if (rms_hit(wb_adr_i, OFS_CAUSE)) begin
                s_nxt.rdata[7:0] = s_r.cause;
            end else if (rms_hit(wb_adr_i, OFS_STATUS)) begin
                s_nxt.rdata[8:0] = {s_r.tx_busy, s_r.rs, s_r.ffs, s_r.dbg_func,
                                    s_r.bg_mode, s_r.sys_reset};
            end else if (rms_hit(wb_adr_i, OFS_INT_STAT)) begin
                s_nxt.rdata[7:0] = s_r.int_stat;
            end else if (rms_hit(wb_adr_i, OFS_INT_MASK)) begin
                s_nxt.rdata[7:0] = s_r.int_mask;
            end else if (rms_hit(wb_adr_i, OFS_BDC_TX)) begin
                s_nxt.rdata[7:0] = s_r.tx;
            end else if (rms_hit(wb_adr_i, OFS_BDC_RX)) begin
                s_nxt.rdata[7:0] = s_r.rx;
            end
        end
        if (wr) begin
            if (rms_hit(wb_adr_i, OFS_CTRL)) begin
                // [RQ2] Clock source select
                s_nxt.cgo_sel = (wb_dat_i[CTRL_CGO_SEL+1]) ? CGO_DCO :
                                (wb_dat_i[CTRL_CGO_SEL] ? CGO_EXT : CGO_XTAL);
                // [RQ12] Debug clock select
                s_nxt.bdc_clk_sel = wb_dat_i[CTRL_BDC_CLK];
                // [RQ13] Reference clock routing
                s_nxt.rti_sel  = wb_dat_i[CTRL_RTI_SEL];
                s_nxt.adc_sel  = wb_dat_i[CTRL_ADC_SEL];
                s_nxt.stop_rec = wb_dat_i[CTRL_STOP_RC];
                sw_rst         = wb_dat_i[CTRL_SW_RST];
            end
            if (rms_hit(wb_adr_i, OFS_INT_STAT)) begin
                clr = wb_dat_i[7:0];
            end
            if (rms_hit(wb_adr_i, OFS_INT_MASK)) begin
                s_nxt.int_mask = wb_dat_i[7:0];
            end
            if (rms_hit(wb_adr_i, OFS_BDC_TX) && s_r.dbg_func && !s_r.tx_busy) begin
                s_nxt.tx      = wb_dat_i[7:0];
                s_nxt.tx_busy = 1'b1;
                s_nxt.bitn    = 3'd0;
            end
        end

        // ************************************************************
        // Reset sequencer
        // ************************************************************
        int_trig = lvd_i | cop_i | ilop_i | ilad_i | sw_rst;
        ext_trig = ~s_r.rpin_s[1];
        case (s_r.rs)
            RS_RUN: begin
                if (int_trig || ext_trig) begin
                    // [RQ5] Cause decode
                    s_nxt.cause = 8'h00;
                    s_nxt.cause[CAUSE_PIN]  = ~int_trig & ext_trig;
                    s_nxt.cause[CAUSE_COP]  = cop_i;
                    s_nxt.cause[CAUSE_ILOP] = ilop_i;
                    s_nxt.cause[CAUSE_ILAD] = ilad_i;
                    s_nxt.cause[CAUSE_LVD]  = lvd_i;
                    s_nxt.cause[CAUSE_SW]   = sw_rst;
                    s_nxt.internal_src      = int_trig;
                    // [RQ14] Hold internal logic
                    s_nxt.sys_reset = 1'b1;
                    s_nxt.dbg_func  = 1'b0;
                    s_nxt.bs        = BD_IDLE;
                    s_nxt.tx_busy   = 1'b0;
                    s_nxt.bitn      = 3'd0;
                    s_nxt.dbg_oe    = 1'b0;
                    // [RQ3] Start low drive
                    s_nxt.rpin_oe   = 1'b1;
                    s_nxt.rcnt      = 6'd0;
                    s_nxt.rs        = RS_DRIVE;
                end
            end
            RS_DRIVE: begin
                // [RQ3] Low for 34 cycles
                s_nxt.rcnt = s_r.rcnt + 6'd1;
                if (s_r.rcnt == RST_DRIVE_CYC - 6'd1) begin
                    s_nxt.rpin_oe = 1'b0;
                    s_nxt.rcnt    = 6'd0;
                    s_nxt.rs      = RS_WAIT;
                end
            end
            RS_WAIT: begin
                // [RQ3] Sample 38 cycles later
                s_nxt.rcnt = s_r.rcnt + 6'd1;
                if (s_r.rcnt == RST_SAMPLE_CYC - 6'd1) begin
                    if (s_r.rpin_s[1]) begin
                        release_now = 1'b1;
                    end else begin
                        // [RQ4] Unexpected low sample
                        if (s_r.internal_src) begin
                            ev[EV_PINLOW] = 1'b1;
                        end
                        s_nxt.cause[CAUSE_PIN] = 1'b1;
                        s_nxt.rs               = RS_HOLD;
                    end
                end
            end
            RS_HOLD: begin
                // [RQ14] Wait for pin release
                if (s_r.rpin_s[1]) begin
                    release_now = 1'b1;
                end
            end
            default: begin
                s_nxt.rs = RS_RUN;
            end
        endcase
        if (release_now) begin
            // [RQ6] Latch mode at release
            s_nxt.bg_mode   = ~s_r.dpin_s[1];
            // [RQ7] Background mode event
            ev[EV_BGMODE]   = ~s_r.dpin_s[1];
            // [RQ8] Pin becomes debug wire
            s_nxt.dbg_func  = 1'b1;
            s_nxt.sys_reset = 1'b0;
            s_nxt.rs        = RS_RUN;
            ev[EV_DONE]     = 1'b1;
        end

        // ************************************************************
        // Debug bit engine
        // ************************************************************
        low_end = s_r.tx[7] ? BDC_ONE_LOW_END : BDC_ZERO_LOW_END;
        case (s_r.bs)
            BD_IDLE: begin
                if (s_r.dbg_func && s_r.dpin_prev && !s_r.dpin_s[1] && !s_r.dbg_oe) begin
                    s_nxt.bs   = BD_BIT;
                    s_nxt.bcnt = 4'd0;
                    if (s_r.tx_busy) begin
                        s_nxt.dbg_o  = 1'b0;
                        s_nxt.dbg_oe = 1'b1;
                    end
                end
            end
            BD_BIT: begin
                // [RQ9] Sixteen cycle bit time
                s_nxt.bcnt = s_r.bcnt + 4'd1;
                if (s_r.tx_busy) begin
                    // [RQ10] Speedup pulse then release
                    if (s_r.bcnt == low_end) begin
                        s_nxt.dbg_o = 1'b1;
                    end else if (s_r.bcnt == low_end + 4'd1) begin
                        s_nxt.dbg_oe = 1'b0;
                        s_nxt.dbg_o  = 1'b0;
                    end
                end else if (s_r.bcnt == BDC_SAMPLE_AT) begin
                    s_nxt.rx = {s_r.rx[6:0], s_r.dpin_s[1]};
                end
                if (s_r.bcnt == BDC_BIT_LAST) begin
                    s_nxt.bs   = BD_IDLE;
                    s_nxt.bitn = s_r.bitn + 3'd1;
                    if (s_r.tx_busy) begin
                        s_nxt.tx = {s_r.tx[6:0], 1'b0};
                    end
                    if (s_r.bitn == BDC_LAST_BIT) begin
                        ev[EV_TX]     = s_r.tx_busy;
                        ev[EV_RX]     = ~s_r.tx_busy;
                        s_nxt.tx_busy = 1'b0;
                    end
                end
            end
            default: begin
                s_nxt.bs = BD_IDLE;
            end
        endcase

        // ************************************************************
        // Fixed-frequency select
        // ************************************************************
        if (cgo_tick_i && s_r.cgo_cnt != 8'hFF) begin
            s_nxt.cgo_cnt = s_r.cgo_cnt + 8'd1;
        end
        if (erc_tick_i) begin
            s_nxt.win_cnt  = s_r.win_cnt + 4'd1;
            s_nxt.ff_phase = ~s_r.ff_phase;
            if (s_r.win_cnt == FF_WIN_LAST) begin
                // [RQ1] Compare against four times reference
                s_nxt.ffs     = (s_nxt.cgo_cnt > FF_THRESH);
                ev[EV_FFS]    = (s_nxt.ffs != s_r.ffs);
                s_nxt.cgo_cnt = 8'd0;
            end
        end
        // [RQ1] Reference over two or bus clock
        s_nxt.ff_tick = s_nxt.ffs ? (erc_tick_i & s_r.ff_phase) : 1'b1;

        // ************************************************************
        // Interrupts and clocks
        // ************************************************************
        s_nxt.int_stat = (s_r.int_stat & ~clr) | ev;
        s_nxt.irq      = |(s_nxt.int_stat & s_nxt.int_mask);
        // [RQ11] Self clock during reset
        s_nxt.selfclk  = (s_nxt.rs != RS_RUN) | s_nxt.stop_rec;
    end

    // ************************************************************
    // State register
    // ************************************************************
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            s_r <= RMS_STATE_RST;
        end else begin
            s_r <= s_nxt;
        end
    end

    // ************************************************************
    // Outputs
    // ************************************************************
    assign wb_dat_o            = s_r.rdata;
    assign wb_ack_o            = s_r.ack;
    assign rst_pin_o           = s_r.rpin_o;
    assign rst_pin_oe_o        = s_r.rpin_oe;
    assign dbg_pin_o           = s_r.dbg_o;
    assign dbg_pin_oe_o        = s_r.dbg_oe;
    assign sys_reset_o         = s_r.sys_reset;
    assign bg_mode_o           = s_r.bg_mode;
    assign dbg_func_o          = s_r.dbg_func;
    assign fixed_freq_select_o = s_r.ffs;
    assign ff_tick_o           = s_r.ff_tick;
    assign cgo_sel_o           = s_r.cgo_sel;
    assign bdc_clk_sel_o       = s_r.bdc_clk_sel;
    assign rti_clk_sel_o       = s_r.rti_sel;
    assign adc_alt_clk_sel_o   = s_r.adc_sel;
    assign selfclk_run_o       = s_r.selfclk;
    assign irq_o               = s_r.irq;

endmodule

`default_nettype wire

/* verification/rms_reset_seq_sva.sv */
/* Port checker for the reset sequencer.
   Assumes one bus clock and a sync active-high reset. */
`timescale 1ns/1ps
`default_nettype none
module rms_reset_seq_sva (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_ack_o,
    input wire logic rst_pin_oe_o,
    input wire logic sys_reset_o,
    input wire logic dbg_func_o,
    input wire logic bg_mode_o,
    input wire logic fixed_freq_select_o,
    input wire logic ff_tick_o,
    input wire logic dbg_pin_oe_o,
    input wire logic dbg_pin_o
);
    // *****
    // Counters
    // *****
    logic [7:0] oe_cnt;
    logic [7:0] wt_cnt;
    always_ff @(posedge clk_i) begin
        if (rst_i || !rst_pin_oe_o) begin
            oe_cnt <= 8'h00;
        end else begin
            oe_cnt <= oe_cnt + 8'h01;
        end
        if (rst_i || rst_pin_oe_o || !sys_reset_o) begin
            wt_cnt <= 8'h00;
        end else if (wt_cnt != 8'hFF) begin
            wt_cnt <= wt_cnt + 8'h01;
        end
    end
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    // *****
    // Properties
    // *****
    oe_len_a: assert property ($fell(rst_pin_oe_o) |-> oe_cnt == 8'h22)
        else $error("pin drive length");
    rel_wait_a: assert property ($fell(sys_reset_o) |-> wt_cnt >= 8'h26)
        else $error("early release");
    func_rel_a: assert property ($fell(sys_reset_o) |-> dbg_func_o)
        else $error("no debug function");
    mode_in_a: assert property (sys_reset_o && $past(sys_reset_o) |-> !dbg_func_o)
        else $error("debug function in reset");
    mode_hold_a: assert property (!sys_reset_o && !$past(sys_reset_o) |-> $stable(bg_mode_o))
        else $error("mode changed in run");
    ack_one_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o ##1 !wb_ack_o)
        else $error("bus answer");
    ff_pulse_a: assert property (fixed_freq_select_o && ff_tick_o |=> !ff_tick_o
        || !fixed_freq_select_o)
        else $error("fixed tick rate");
    speedup_a: assert property (dbg_pin_oe_o && dbg_pin_o |=> !dbg_pin_oe_o)
        else $error("speedup too long");
    c_rel: cover property ($fell(sys_reset_o) && bg_mode_o);
    c_spd: cover property (dbg_pin_oe_o && dbg_pin_o);
    c_ffs: cover property ($rose(fixed_freq_select_o));
endmodule
bind rms_reset_seq rms_reset_seq_sva i_rms_reset_seq_sva (.*);
`default_nettype wire

/* verification/rms_dbg_pod.sv */
/* Debug pod and reset switch on the two open-drain pins.
   Assumes the bench resolves both wires with pullups. */
`timescale 1ns/1ps
`default_nettype none
module rms_dbg_pod (
    input  wire logic clk_i,
    input  wire logic dbg_pin_i,
    output logic      rst_oe_o,
    output logic      dbg_oe_o,
    output logic      dbg_o
);
    logic ms_low = 1'b0;
    logic bit_oe = 1'b0;
    initial rst_oe_o = 1'b0;
    initial dbg_o = 1'b0;
    assign dbg_oe_o = ms_low | bit_oe;
    task automatic press(input int n);
        @(posedge clk_i);
        rst_oe_o <= 1'b1;
        repeat (n) @(posedge clk_i);
        rst_oe_o <= 1'b0;
    endtask
    task automatic hold_ms(input logic v);
        @(posedge clk_i);
        ms_low <= v;
    endtask
    task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
        int lo;
        for (int i = 7; i >= 0; i--) begin
            lo = tx[i] ? 4 : 16;
            for (int c = 0; c < 24; c++) begin
                @(posedge clk_i);
                if (c == 14) rx[i] = dbg_pin_i;
                bit_oe <= (c <= lo);
                dbg_o <= (c == lo);
            end
        end
    endtask
endmodule
`default_nettype wire

/* verification/tb.sv */
/* Bench for the reset sequencer with a debug pod model.
   Assumes the design answers the bus one cycle after a request. */
`timescale 1ns/1ps
`default_nettype none
module tb;
    import rms_pkg::*;
    logic clk_i = 1'b0, rst_i = 1'b1, wb_cyc_i = 1'b0, wb_stb_i = 1'b0;
    logic wb_we_i = 1'b0, cgo_tick_i = 1'b0, erc_tick_i = 1'b0;
    logic [7:0] wb_adr_i = 8'h00;
    logic [31:0] wb_dat_i = 32'h0, wb_dat_o, q, v;
    logic [3:0] wb_sel_i = 4'h0, src = 4'h0;
    wire logic lvd_i, cop_i, ilop_i, ilad_i, rst_pin_i, dbg_pin_i;
    logic wb_ack_o, rst_pin_o, rst_pin_oe_o, dbg_pin_o, dbg_pin_oe_o, sys_reset_o;
    logic bg_mode_o, dbg_func_o, fixed_freq_select_o, ff_tick_o, bdc_clk_sel_o;
    logic rti_clk_sel_o, adc_alt_clk_sel_o, selfclk_run_o, irq_o, p_rst, p_oe, p_o;
    logic [1:0] cgo_sel_o;
    logic [7:0] b, r;
    int mismatches = 0, n_checks = 0, p_erc = 4, p_cgo = 2, ec = 0, cc = 0;
    int n, pe, pc, cbit [5] = '{CAUSE_LVD, CAUSE_COP, CAUSE_ILOP, CAUSE_ILAD, CAUSE_SW};
    assign {ilad_i, ilop_i, cop_i, lvd_i} = src;
    assign rst_pin_i = !((rst_pin_oe_o && !rst_pin_o) || p_rst);
    assign dbg_pin_i = !((dbg_pin_oe_o && !dbg_pin_o) || (p_oe && !p_o));
    always #5 clk_i = !clk_i;
    always @(posedge clk_i) begin
        ec <= (ec + 1 >= p_erc) ? 0 : ec + 1;
        cc <= (cc + 1 >= p_cgo) ? 0 : cc + 1;
        erc_tick_i <= (ec == 0);
        cgo_tick_i <= (cc == 0);
    end
    rms_reset_seq i_rms_reset_seq (.*);
    rms_dbg_pod i_rms_dbg_pod (.clk_i(clk_i), .dbg_pin_i(dbg_pin_i), .rst_oe_o(p_rst),
        .dbg_oe_o(p_oe), .dbg_o(p_o));
    function automatic logic [31:0] exp_src(input int k);
        exp_src = k[1] ? 32'(CGO_DCO) : 32'(k);
    endfunction
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        n_checks++;
        if (g !== e) begin
            mismatches++;
            $display("[ERR] %s exp %h got %h", nm, e, g);
        end
    endtask
    task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d,
        output logic [31:0] o);
        @(posedge clk_i);
        {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i, wb_sel_i} <= {2'b11, we, a, d, 4'hF};
        do @(posedge clk_i); while (wb_ack_o !== 1'b1);
        o = wb_dat_o;
        {wb_cyc_i, wb_stb_i} <= 2'b00;
    endtask
    task automatic wait_rel();
        int i;
        i = 0;
        repeat (3) @(posedge clk_i);
        while (sys_reset_o !== 1'b0 && i < 600) begin
            @(posedge clk_i);
            i++;
        end
        chk("released", 0, sys_reset_o);
    endtask
    task automatic summarize();
        $display("checks %0d mismatches %0d", n_checks, mismatches);
        if (mismatches == 0 && n_checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    initial begin
        #500000;
        mismatches++;
        summarize();
    end
    initial begin
        void'($urandom(32'h6dd1));
        repeat (4) @(posedge clk_i);
        rst_i <= 1'b0;
        wait_rel();
        wb(0, OFS_CAUSE, 0, q);
        chk("cause", 1 << CAUSE_POR, q);
        chk("bg_mode", 0, bg_mode_o);
        chk("dbg_func", 1, dbg_func_o);
        wb(0, OFS_STATUS, 0, q);
        chk("status", {RS_RUN, 4'h4}, q);
        for (int k = 0; k < 4; k++) begin
            v = $urandom & 32'h3C | k;
            wb(1, OFS_CTRL, v, q);
            chk("cgo_sel", exp_src(k), cgo_sel_o);
            chk("bdc_clk", v[2], bdc_clk_sel_o);
            chk("rti_sel", v[3], rti_clk_sel_o);
            chk("adc_sel", v[4], adc_alt_clk_sel_o);
            chk("selfclk", v[5], selfclk_run_o);
            wb(0, OFS_CTRL, 0, q);
            chk("ctrl", v & 32'h3C | exp_src(k), q);
        end
        wb(0, 8'h1C, 0, q);
        chk("unmapped", 0, q);
        for (int m = 0; m < 3; m++) begin
            wb(1, m == 2 ? OFS_INT_STAT : OFS_INT_MASK, m == 0 ? 0 : 1 << EV_DONE, q);
            repeat (2) @(posedge clk_i);
            chk("irq", m == 1, irq_o);
        end
        b = $urandom;
        i_rms_dbg_pod.xfer(b, r);
        wb(0, OFS_BDC_RX, 0, q);
        chk("bdc_rx", b, q);
        b = $urandom;
        wb(1, OFS_BDC_TX, b, q);
        i_rms_dbg_pod.xfer(8'hFF, r);
        chk("bdc_tx", b, r);
        wb(0, OFS_INT_STAT, 0, q);
        chk("ev_rx_tx", 32'h18, q & 32'h18);
        for (int s = 0; s < 5; s++) begin
            if (s < 4) begin
                @(posedge clk_i);
                src <= 4'h1 << s;
                @(posedge clk_i);
                src <= 4'h0;
            end else begin
                wb(1, OFS_CTRL, 32'h80, q);
            end
            wait_rel();
            wb(0, OFS_CAUSE, 0, q);
            chk("cause", 1 << cbit[s], q);
        end
        i_rms_dbg_pod.hold_ms(1'b1);
        i_rms_dbg_pod.press(10);
        wait_rel();
        chk("bg_mode", 1, bg_mode_o);
        wb(0, OFS_CAUSE, 0, q);
        chk("cause", 1 << CAUSE_PIN, q);
        wb(0, OFS_INT_STAT, 0, q);
        chk("ev_bgmode", 1, q[EV_BGMODE]);
        i_rms_dbg_pod.hold_ms(1'b0);
        fork
            i_rms_dbg_pod.press(150);
        join_none
        src <= 4'h2;
        @(posedge clk_i);
        src <= 4'h0;
        repeat (100) @(posedge clk_i);
        chk("held", 1, sys_reset_o);
        chk("selfclk_rst", 1, selfclk_run_o);
        wait_rel();
        wb(0, OFS_CAUSE, 0, q);
        chk("cause", 1 << CAUSE_COP | 1 << CAUSE_PIN, q);
        wb(0, OFS_INT_STAT, 0, q);
        chk("ev_pinlow", 1, q[EV_PINLOW]);
        for (int t = 0; t < 5; t++) begin
            pc = t == 0 ? 1 : 1 + $urandom % 2;
            pe = t == 0 ? 9 : 3 + $urandom % 7;
            if (pe == 4 * pc) pe++;
            p_cgo <= pc;
            p_erc <= pe;
            repeat (400) @(posedge clk_i);
            chk("ffs", pe > 4 * pc, fixed_freq_select_o);
            n = 0;
            repeat (16 * pe) begin
                @(posedge clk_i);
                n += ff_tick_o;
            end
            chk("ff_ticks", 1, pe > 4 * pc ? n inside {[7:9]} : n == 16 * pe);
        end
        summarize();
    end
endmodule
`default_nettype wire
